//--- dv/i2ce_eeprom_model.sv
`timescale 1ns/100ps
`default_nettype none
module i2ce_eeprom_model (
  input  wire logic       scl_w,
  input  wire logic       sda_w,
  input  wire logic       wp,
  input  wire logic       nack_addr,
  input  wire logic       stretch,
  input  wire logic [3:0] busy_polls,
  output logic            scl_pull,
  output logic            sda_pull,
  output logic            got,
  output logic [7:0]      got_val
);
  logic [7:0]  mem [int];
  logic [15:0] ptr;
  int          busy_left;
  logic        wrote;

  // ---------------------------------------------------------------------
  // Bit level
  // ---------------------------------------------------------------------
  // Event code: 0 plain bit, 1 start seen, 2 stop seen.
  task automatic rx_bit(output logic b, output int ev);
    @(posedge scl_w);
    b = sda_w;
    ev = 0;
    forever
    begin
      @(scl_w or sda_w);
      if (scl_w !== 1'b1)
        break;
      if (sda_w !== b)
      begin
        ev = (sda_w === 1'b1) ? 2 : 1;
        break;
      end
    end
  endtask

  task automatic ack_bit(input logic pull);
    sda_pull = pull;
    @(posedge scl_w);
    @(negedge scl_w);
    sda_pull = 1'b0;
  endtask

  // ---------------------------------------------------------------------
  // Frame level
  // ---------------------------------------------------------------------
  task automatic frame();
    logic [7:0] v;
    logic       b;
    int         ev;
    int         idx;
    logic       rd;
    idx = 0;
    rd = 1'b0;
    v = 8'h00;
    forever
    begin
      for (int n = 0; n < 8; n++)
      begin
        rx_bit(b, ev);
        if (ev == 2)
        begin
          if (wrote)
            busy_left = busy_polls;
          wrote = 1'b0;
          return;
        end
        if (ev == 1)
        begin
          idx = 0;
          n = -1;
        end
        else
          v = {v[6:0], b};
      end
      got_val = v;
      got = 1'b1;
      #1 got = 1'b0;
      if (idx == 0)
      begin
        rd = v[0];
        if (stretch)
        begin
          // Holding the clock low forever is the fault the master must survive.
          scl_pull = 1'b1;
          wait (!stretch);
          scl_pull = 1'b0;
          return;
        end
        if (nack_addr || busy_left > 0)
        begin
          if (busy_left > 0)
            busy_left--;
          ack_bit(1'b0);
        end
        else
          ack_bit(1'b1);
        if (rd)
        begin
          do
          begin
            v = mem.exists(int'(ptr)) ? mem[int'(ptr)] : 8'h00;
            for (int n = 7; n >= 0; n--)
              ack_bit(!v[n]);
            @(posedge scl_w);
            b = sda_w;
            @(negedge scl_w);
            ptr++;
          end
          while (b === 1'b0);
          return;
        end
      end
      else if (idx == 1)
      begin
        ptr[15:8] = v;
        ack_bit(1'b1);
      end
      else if (idx == 2)
      begin
        ptr[7:0] = v;
        ack_bit(1'b1);
      end
      else
      begin
        if (wp === 1'b0)
          mem[int'(ptr)] = v;
        ptr++;
        wrote = 1'b1;
        ack_bit(1'b1);
      end
      idx++;
    end
  endtask

  initial
  begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    got = 1'b0;
    got_val = 8'h00;
    ptr = 16'h0000;
    busy_left = 0;
    wrote = 1'b0;
    forever
    begin
      @(negedge sda_w iff scl_w === 1'b1);
      frame();
    end
  end
endmodule
`default_nettype wire

//--- dv/test_i2c_master_eeprom_access.sv
`timescale 1ns/100ps
`default_nettype none
module test_i2c_master_eeprom_access;
  logic        clk_sys, rst, start, cap_large, wr_valid, wr_ready;
  logic        rd_valid, busy, done, timeout_err, nack_err;
  logic        scl_oe, sda_oe, scl_pull, sda_pull, nack_addr, stretch;
  logic        m_got, wp_lvl;
  logic [3:0]  polls;
  logic [2:0]  page_sel;
  logic [15:0] mem_addr;
  logic [7:0]  wr_data, rd_data, m_val, a;
  logic [7:0]  exp_wire[$], exp_rd[$], fifo_q[$];
  logic [1:0]  exp_flags[$];
  int          seed = 32'h7891;
  int          fails = 0;
  int          tests_run = 0;
  int          cyc = 0;
  // Open-drain lines with pull-ups: low while any party pulls.
  wire logic   scl_w = !(scl_oe || scl_pull);
  wire logic   sda_w = !(sda_oe || sda_pull);

  // A normal low phase lasts about 25 ticks and a stalled ack bit ends
  // near 50, so 40 lets the timeout win over the refused address.
  i2ce_top #(.TOUT_TICKS(40)) dut (
    .clk_sys(clk_sys), .rst(rst), .start(start), .cap_large(cap_large),
    .page_sel(page_sel), .mem_addr(mem_addr), .wr_valid(wr_valid),
    .wr_data(wr_data), .wr_ready(wr_ready), .rd_data(rd_data),
    .rd_valid(rd_valid), .busy(busy), .done(done),
    .timeout_err(timeout_err), .nack_err(nack_err), .scl_in(scl_w),
    .scl_out(), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(),
    .sda_oe(sda_oe));

  i2ce_eeprom_model mdl (
    .scl_w(scl_w), .sda_w(sda_w), .wp(wp_lvl), .nack_addr(nack_addr),
    .stretch(stretch), .busy_polls(polls), .scl_pull(scl_pull),
    .sda_pull(sda_pull), .got(m_got), .got_val(m_val));

  // ---------------------------------------------------------------------
  // Checking
  // ---------------------------------------------------------------------
  task automatic cmp_byte(input string what, input logic [7:0] e,
                          input logic [7:0] s);
    tests_run++;
    if (s !== e)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, e, s);
    end
  endtask

  task automatic cmp_flag(input string what, input logic [1:0] e,
                          input logic [1:0] s);
    tests_run++;
    if (s !== e)
    begin
      fails++;
      $display("ERROR %s expected %b seen %b", what, e, s);
    end
  endtask

  task automatic give_verdict();
    $display("Checks run %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge m_got)
    cmp_byte("wire byte", exp_wire.size() ? exp_wire.pop_front() : 8'hxx,
             m_val);

  always @(negedge clk_sys)
  begin
    if (rd_valid === 1'b1)
      cmp_byte("read byte", exp_rd.size() ? exp_rd.pop_front() : 8'hxx,
               rd_data);
    if (done === 1'b1)
    begin
      cmp_flag("flags", exp_flags.size() ? exp_flags.pop_front() : 2'bxx,
               {timeout_err, nack_err});
      cmp_flag("lines", 2'b00, {scl_oe, sda_oe});
      cmp_flag("busy", 2'b00, {1'b0, busy});
    end
  end

  // The whole run needs roughly 130k cycles, mostly the full sequence.
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 250000)
    begin
      fails++;
      give_verdict();
    end
  end

  // ---------------------------------------------------------------------
  // Stimulus
  // ---------------------------------------------------------------------
  function automatic logic [7:0] addr_byte(input logic cl,
                                           input logic [2:0] pg);
    return cl ? {4'hA, 1'b0, pg[1:0], 1'b0} : {4'hA, pg, 1'b0};
  endfunction

  task automatic kick(input logic cl, input logic [2:0] pg);
    @(negedge clk_sys);
    cap_large = cl;
    page_sel = pg;
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
    cmp_flag("busy after start", 2'b01, {1'b0, busy});
  endtask

  task automatic wait_done();
    while (done !== 1'b1)
      @(negedge clk_sys);
    @(negedge clk_sys);
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  initial
  begin
    rst = 1'b1;
    {start, cap_large, wr_valid, nack_addr, stretch, wp_lvl} = 6'h00;
    page_sel = 3'b000;
    polls = 4'h1;
    mem_addr = 16'h0000;
    wr_data = 8'h00;
    repeat (12) @(negedge clk_sys);
    rst = 1'b0;
    for (int i = 0; i < 32; i++)
    begin
      @(negedge clk_sys);
      wr_valid = 1'b1;
      wr_data = 8'($random(seed));
      fifo_q.push_back(wr_data);
    end
    @(negedge clk_sys);
    wr_data = 8'($random(seed));
    cmp_flag("fifo full", 2'b00, {1'b0, wr_ready});
    @(negedge clk_sys);
    wr_valid = 1'b0;
    // Full write, one or two refused polls, accepted poll, read back.
    mem_addr = 16'($random(seed));
    polls = 4'(1 + ($random(seed) & 1));
    a = addr_byte(1'b0, 3'b101);
    exp_wire = {a, mem_addr[15:8], mem_addr[7:0]};
    for (int i = 0; i < 8; i++)
    begin
      exp_wire.push_back(fifo_q[i]);
      exp_rd.push_back(fifo_q[i]);
    end
    repeat (polls + 1) exp_wire.push_back(a);
    exp_wire = {exp_wire, a, mem_addr[15:8], mem_addr[7:0], a | 8'h01};
    exp_flags.push_back(2'b00);
    kick(1'b0, 3'b101);
    repeat (300) @(negedge clk_sys);
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
    wait_done();
    // Large part, address refused: abort with error flag.
    nack_addr = 1'b1;
    exp_wire.push_back(addr_byte(1'b1, 3'b111));
    exp_flags.push_back(2'b01);
    kick(1'b1, 3'b111);
    wait_done();
    nack_addr = 1'b0;
    // Clock held low by the far side: timeout, errors reset at start.
    stretch = 1'b1;
    exp_wire.push_back(addr_byte(1'b0, 3'b000));
    exp_flags.push_back(2'b10);
    kick(1'b0, 3'b000);
    wait_done();
    stretch = 1'b0;
    repeat (20) @(negedge clk_sys);
    cmp_flag("notes left", 2'b00,
             {exp_wire.size() != 0, exp_rd.size() != 0});
    give_verdict();
  end
endmodule
`default_nettype wire

//--- rtl/i2ce_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module i2ce_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 32
) (
  input  wire logic  clk_sys,
  input  wire logic  rst,
  i2ce_fifo_if.fifo  fif
);
  localparam int unsigned AW = $clog2(D);

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wptr_r;
  logic [AW-1:0] rptr_r;
  logic [AW:0]   cnt_r;
  logic          full_r;
  logic          push;
  logic          pop;

  assign push          = fif.in_valid && !full_r;
  assign pop           = fif.out_ready && (cnt_r != '0);
  assign fif.in_ready  = !full_r;
  assign fif.out_valid = (cnt_r != '0);
  assign fif.out_data  = mem[rptr_r];

  // ----------------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (push)
    begin
      mem[wptr_r] <= fif.in_data;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      wptr_r <= '0;
      rptr_r <= '0;
      cnt_r  <= '0;
      full_r <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        wptr_r <= AW'(wptr_r + 1'b1);
      end
      if (pop)
      begin
        rptr_r <= AW'(rptr_r + 1'b1);
      end
      // Full is kept as a flop so the ready seen by the source is clean.
      if (push && !pop)
      begin
        cnt_r  <= (AW+1)'(cnt_r + 1'b1);
        full_r <= (cnt_r == (AW+1)'(D - 1));
      end
      else if (pop && !push)
      begin
        cnt_r  <= (AW+1)'(cnt_r - 1'b1);
        full_r <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

//--- rtl/i2ce_fifo_if.sv
`timescale 1ns/100ps
`default_nettype none
interface i2ce_fifo_if #(parameter int unsigned W = 8);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;

  modport fifo (input in_valid, input in_data, output in_ready,
                output out_valid, output out_data, input out_ready);
  modport user (output in_valid, output in_data, input in_ready,
                input out_valid, input out_data, output out_ready);
endinterface
`default_nettype wire

//--- rtl/i2ce_pkg.sv
package i2ce_pkg;

  // ----------------------------------------------------------------------
  // Clocks and timing
  // ----------------------------------------------------------------------
  localparam int unsigned SYS_HZ        = 200_000_000;
  localparam int unsigned REF_HZ        = 20_000_000;
  localparam int unsigned BIT_RATE_BPS  = 400_000;
  localparam int unsigned REF_DIV_CYC   = SYS_HZ / REF_HZ;
  localparam int unsigned QTR_CYC       = SYS_HZ / (BIT_RATE_BPS * 4);
  localparam int unsigned TOUT_BITS     = 16;
  localparam int unsigned TOUT_REF_TICK = 1 << TOUT_BITS;

  // ----------------------------------------------------------------------
  // Transfer layout
  // ----------------------------------------------------------------------
  localparam int unsigned FIFO_W        = 8;
  localparam int unsigned FIFO_D        = 32;
  localparam logic [3:0]  ADDR_PATTERN  = 4'h0A;
  localparam logic [3:0]  STEP_WR_STOP  = 4'h000C;
  localparam logic [3:0]  STEP_POLL_END = 4'h0002;
  localparam logic [3:0]  STEP_RSTART   = 4'h0004;
  localparam logic [3:0]  STEP_ADDR_RD  = 4'h0005;
  localparam logic [3:0]  STEP_RX_FIRST = 4'h0006;
  localparam logic [3:0]  STEP_RX_LAST  = 4'h000D;
  localparam logic [3:0]  STEP_RD_STOP  = 4'h000E;
  localparam logic [3:0]  BIT_ACK       = 4'h0008;

  typedef enum logic [1:0] {
    STG_WR   = 2'b00,
    STG_POLL = 2'b01,
    STG_RD   = 2'b10
  } i2ce_stage_t;

  typedef enum logic [1:0] {
    OP_START = 2'b00,
    OP_TX    = 2'b01,
    OP_RX    = 2'b10,
    OP_STOP  = 2'b11
  } i2ce_op_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_NEXT  = 3'b001,
    ST_START = 3'b010,
    ST_TX    = 3'b011,
    ST_RX    = 3'b100,
    ST_STOP  = 3'b101
  } i2ce_state_t;

endpackage

//--- rtl/i2ce_top.sv
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Sole bus master, transmits and receives itself.
// - Seven-bit addressing, 400 Kbps from 200 MHz.
// - Write eight bytes, then read them back.
// - Acknowledge polling until the write completes.
// - Timeout counts only while clock line low.
// - Sixteen-bit reference-clock timeout, about 3.277 ms.
// - Address byte upper nibble 1010, bit0 direction.
// - Small memory: page in address bits 1-3.
// - Large memory: page in address bits 1-2.
// - Write: start, address, two-byte pointer, data, stop.
// - Read: restart, ack each byte, nack last, stop.
module i2ce_top
  import i2ce_pkg::*;
#(
  parameter int unsigned TOUT_TICKS = TOUT_REF_TICK
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic        cap_large,
  input  wire logic [2:0]  page_sel,
  input  wire logic [15:0] mem_addr,
  input  wire logic        wr_valid,
  input  wire logic [7:0]  wr_data,
  output logic             wr_ready,
  output logic [7:0]       rd_data,
  output logic             rd_valid,
  output logic             busy,
  output logic             done,
  output logic             timeout_err,
  output logic             nack_err,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe
);

  // ----------------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------------
  function automatic i2ce_op_t op_of(i2ce_stage_t stg, logic [3:0] stp);
    op_of = OP_TX;
    case (stg)
      STG_WR:   if (stp == '0) op_of = OP_START;
                else if (stp == STEP_WR_STOP) op_of = OP_STOP;
      STG_POLL: if (stp == '0) op_of = OP_START;
                else if (stp == STEP_POLL_END) op_of = OP_STOP;
      default:  if (stp == '0 || stp == STEP_RSTART) op_of = OP_START;
                else if (stp == STEP_RD_STOP) op_of = OP_STOP;
                else if (stp >= STEP_RX_FIRST) op_of = OP_RX;
    endcase
  endfunction

  function automatic logic [7:0] addr_byte(logic big, logic [2:0] pg,
                                           logic rw);
    // Bit 3 of the large part is a strap there; it is sent as zero.
    addr_byte = big ? {ADDR_PATTERN, 1'b0, pg[1:0], rw}
                    : {ADDR_PATTERN, pg, rw};
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  i2ce_state_t state_r;
  i2ce_stage_t stage_r;
  logic [3:0]  step_r;
  logic [1:0]  q_r;
  logic [3:0]  bit_r;
  logic [7:0]  shift_r;
  logic        ack_r;
  logic        abort_r;
  logic [3:0]  div_r;
  logic [6:0]  qdiv_r;
  logic        ref_en;
  logic        qtick;
  logic [1:0]  scl_sy_r;
  logic [1:0]  sda_sy_r;
  logic [16:0] tout_r;
  logic        tout_hit;
  logic        from_fifo;
  logic [7:0]  tx_byte;
  i2ce_op_t    op_now;

  i2ce_fifo_if #(.W(FIFO_W)) fif ();

  i2ce_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .clk_sys (clk_sys),
    .rst     (rst),
    .fif     (fif)
  );

  assign fif.in_valid = wr_valid;
  assign fif.in_data  = wr_data;
  assign wr_ready     = fif.in_ready;
  assign scl_out      = 1'b0;
  assign sda_out      = 1'b0;

  assign op_now    = op_of(stage_r, step_r);
  assign from_fifo = (stage_r == STG_WR) && (step_r > 4'h3);
  always_comb
  begin
    tx_byte = fif.out_data;
    case (step_r)
      4'h1:         tx_byte = addr_byte(cap_large, page_sel, 1'b0);
      4'h2:         tx_byte = mem_addr[15:8];
      4'h3:         tx_byte = mem_addr[7:0];
      // Step five carries FIFO data while writing, the read address later.
      STEP_ADDR_RD: tx_byte = from_fifo ? fif.out_data
                              : addr_byte(cap_large, page_sel, 1'b1);
      default:      tx_byte = fif.out_data;
    endcase
  end
  // Stall on an empty FIFO holds the clock low; the timeout bounds it.
  assign fif.out_ready = (state_r == ST_NEXT) && (op_now == OP_TX) &&
                         from_fifo && fif.out_valid;

  // ----------------------------------------------------------------------
  // Rate dividers
  // ----------------------------------------------------------------------
  assign ref_en = (div_r == 4'(REF_DIV_CYC - 1));
  assign qtick  = (qdiv_r == 7'(QTR_CYC - 1));
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      div_r  <= '0;
      qdiv_r <= '0;
    end
    else
    begin
      div_r  <= ref_en ? 4'h0 : 4'(div_r + 1'b1);
      qdiv_r <= qtick ? 7'h00 : 7'(qdiv_r + 1'b1);
    end
  end

  // ----------------------------------------------------------------------
  // Line synchronisers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      scl_sy_r <= 2'b11;
      sda_sy_r <= 2'b11;
    end
    else
    begin
      scl_sy_r <= {scl_sy_r[0], scl_in};
      sda_sy_r <= {sda_sy_r[0], sda_in};
    end
  end

  // ----------------------------------------------------------------------
  // Low-clock timeout
  // ----------------------------------------------------------------------
  assign tout_hit = busy && ref_en && !scl_sy_r[1] &&
                    (tout_r == 17'(TOUT_TICKS - 1));
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      tout_r <= '0;
    end
    else if (!busy || scl_sy_r[1] || tout_hit)
    begin
      tout_r <= '0;
    end
    else if (ref_en)
    begin
      tout_r <= 17'(tout_r + 1'b1);
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer and bit engine
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_r  <= ST_IDLE;
      stage_r  <= STG_WR;
      step_r   <= '0;
      q_r      <= '0;
      bit_r    <= '0;
      shift_r  <= '0;
      ack_r    <= 1'b0;
      abort_r  <= 1'b0;
      scl_oe   <= 1'b0;
      sda_oe   <= 1'b0;
      busy     <= 1'b0;
      done     <= 1'b0;
      rd_valid <= 1'b0;
      rd_data  <= '0;
    end
    else
    begin
      done     <= 1'b0;
      rd_valid <= 1'b0;
      if (tout_hit)
      begin
        state_r <= ST_IDLE;
        scl_oe  <= 1'b0;
        sda_oe  <= 1'b0;
        busy    <= 1'b0;
        done    <= 1'b1;
      end
      else
      begin
        case (state_r)
          ST_IDLE:
          begin
            if (start)
            begin
              state_r <= ST_NEXT;
              stage_r <= STG_WR;
              step_r  <= '0;
              abort_r <= 1'b0;
              busy    <= 1'b1;
            end
          end
          ST_NEXT:
          begin
            q_r   <= '0;
            bit_r <= '0;
            case (op_now)
              OP_START: state_r <= ST_START;
              OP_STOP:  state_r <= ST_STOP;
              OP_RX:    state_r <= ST_RX;
              default:
              begin
                if (!from_fifo || fif.out_valid)
                begin
                  shift_r <= tx_byte;
                  state_r <= ST_TX;
                end
              end
            endcase
          end
          ST_START:
          begin
            if (qtick)
            begin
              q_r <= 2'(q_r + 1'b1);
              case (q_r)
                2'd0: sda_oe <= 1'b0;
                2'd1: scl_oe <= 1'b0;
                2'd2: sda_oe <= 1'b1;
                default:
                begin
                  scl_oe  <= 1'b1;
                  step_r  <= 4'(step_r + 1'b1);
                  state_r <= ST_NEXT;
                end
              endcase
            end
          end
          ST_TX, ST_RX:
          begin
            if (qtick)
            begin
              q_r <= 2'(q_r + 1'b1);
              case (q_r)
                2'd0:
                begin
                  if (bit_r == BIT_ACK)
                    sda_oe <= (state_r == ST_RX) &&
                              (step_r != STEP_RX_LAST);
                  else
                    sda_oe <= (state_r == ST_TX) && !shift_r[7];
                end
                2'd1: scl_oe <= 1'b0;
                2'd2:
                begin
                  if (bit_r == BIT_ACK)
                    ack_r <= !sda_sy_r[1];
                  else if (state_r == ST_RX)
                    shift_r <= {shift_r[6:0], sda_sy_r[1]};
                end
                default:
                begin
                  scl_oe <= 1'b1;
                  if (state_r == ST_TX && bit_r != BIT_ACK)
                    shift_r <= {shift_r[6:0], 1'b0};
                  if (bit_r != BIT_ACK)
                    bit_r <= 4'(bit_r + 1'b1);
                  else
                  begin
                    step_r  <= 4'(step_r + 1'b1);
                    state_r <= ST_NEXT;
                    if (state_r == ST_RX)
                    begin
                      rd_data  <= shift_r;
                      rd_valid <= 1'b1;
                    end
                    else if (!ack_r && stage_r != STG_POLL)
                    begin
                      // A refused byte ends the frame at once.
                      abort_r <= 1'b1;
                      state_r <= ST_STOP;
                    end
                  end
                end
              endcase
            end
          end
          ST_STOP:
          begin
            if (qtick)
            begin
              q_r <= 2'(q_r + 1'b1);
              case (q_r)
                2'd0: sda_oe <= 1'b1;
                2'd1: scl_oe <= 1'b0;
                2'd2: sda_oe <= 1'b0;
                default:
                begin
                  step_r  <= '0;
                  state_r <= ST_NEXT;
                  if (abort_r || stage_r == STG_RD)
                  begin
                    state_r <= ST_IDLE;
                    busy    <= 1'b0;
                    done    <= 1'b1;
                  end
                  else if (stage_r == STG_WR)
                    stage_r <= STG_POLL;
                  else if (ack_r)
                    stage_r <= STG_RD;
                end
              endcase
            end
          end
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Error flags
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      timeout_err <= 1'b0;
      nack_err    <= 1'b0;
    end
    else
    begin
      // Start is only taken while idle, so it never meets a set.
      if (tout_hit)
        timeout_err <= 1'b1;
      else if (start && state_r == ST_IDLE)
        timeout_err <= 1'b0;
      if (state_r == ST_STOP && abort_r)
        nack_err <= 1'b1;
      else if (start && state_r == ST_IDLE)
        nack_err <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_bus_released;
    !scl_oe && !sda_oe && !busy;
  endsequence

  chk_idle_quiet: assert property (!busy |-> !scl_oe && !sda_oe)
    else $error("bus driven while idle");
  chk_quarter_rate: assert property (qtick |-> ##125 qtick)
    else $error("quarter-bit tick period wrong");
  chk_ref_rate: assert property (ref_en |-> ##10 ref_en)
    else $error("reference enable period wrong");
  chk_tout_scl_high: assert property (scl_sy_r[1] |=> tout_r == '0)
    else $error("timeout counted while clock high");
  chk_tout_release: assert property (tout_hit |=> s_bus_released ##0
                                     timeout_err)
    else $error("timeout did not release the bus");
  chk_addr_pattern: assert property (state_r == ST_TX && bit_r == '0 &&
    (step_r == 4'h1 || (step_r == STEP_ADDR_RD && stage_r == STG_RD)) |->
    shift_r[7:4] == ADDR_PATTERN &&
    shift_r[0] == (step_r == STEP_ADDR_RD))
    else $error("address byte pattern or direction wrong");
  chk_page_small: assert property (!cap_large && step_r == 4'h1 &&
    state_r == ST_NEXT |-> tx_byte[3:1] == page_sel)
    else $error("small part page bits wrong");
  chk_page_large: assert property (cap_large && step_r == 4'h1 &&
    state_r == ST_NEXT |-> tx_byte[2:1] == page_sel[1:0])
    else $error("large part page bits wrong");
  chk_last_nack: assert property (state_r == ST_RX && bit_r == BIT_ACK &&
    step_r == STEP_RX_LAST && q_r == 2'd1 |-> !sda_oe)
    else $error("last read byte was acknowledged");
  chk_poll_repeat: assert property (state_r == ST_STOP &&
    stage_r == STG_POLL && qtick && q_r == 2'd3 && !ack_r && !abort_r
    |=> stage_r == STG_POLL && state_r == ST_NEXT)
    else $error("poll did not repeat on refusal");
  chk_eight_data: assert property (state_r == ST_NEXT &&
    stage_r == STG_WR |-> step_r <= STEP_WR_STOP)
    else $error("write phase ran past eight data bytes");

endmodule
`default_nettype wire
